/* File: hw/ttsp_pkg.sv */
// constants for the t1 tdm system port and control word decoder
// assumes one 10 MHz system clock; bus clock and line clocks arrive as sampled inputs
// Functional notes
// R01 - serial streams: 2048 kbit/s, 125 us frames of 32 channels, 8 bits each.
// R02 - payload input sampled on bus clock falling edge; frame pulse marks frame start.
// R03 - only 24 of 32 input channels go to the line; other 8 ignored.
// R04 - received line payload shifted onto data output on bus clock rising edges.
// R05 - data output driven in all 32 slots, including the 8 idle ones.
// R06 - status stream: 24 channel words, phase word in 3, master words 15, 31.
// R07 - controller sends channel control words and master words in slots 15, 31; code decodes only the master words, other slots ignored.
// R08 - controller sends ABCD signalling on stream one in each channel's slot.
// R09 - control bit 7 set: raw signalling reported; clear: debounced 6 to 9 ms.
// R10 - control bit 6 set: no zero code suppression on transmit data.
// R11 - bit 5 set with bit 6 clear enables B8ZS; bit 6 overrides it.
// R12 - bits 5 and 6 clear: all-zero channel gets bit 7 forced high.
// R13 - bit 4 set holds 8 kHz pin high; clear toggles it from line clock.
// R14 - external control pin follows control bit 3.
// R15 - ESF and bit 2: send eight ones, eight zeros in data link bits.
// R16 - bit 1 clear: ABCD robbed into bit 8 every sixth frame; set disables.
// R17 - bit 0 set forces bit 2 low in all transmitted channels.
// R18 - second master word bit 4 selects ESF, clear selects D3/D4.
// R19 - control words take effect only after their whole channel is received.
package ttsp_pkg;
    localparam int BUS_CHANNELS = 32;
    localparam int BITS_PER_CHANNEL = 8;
    localparam int LINE_CHANNELS = 24;
    localparam int FRAME_US = 125;
    localparam int DEBOUNCE_US = 6000;
    localparam int DEBOUNCE_FRAMES = DEBOUNCE_US / FRAME_US;
    localparam int FRAMES_PER_SUPERFRAME = 24;
    localparam int ROBBED_PERIOD = 6;
    localparam int EIGHT_KHZ_PERIOD = 193;
    localparam int EIGHT_KHZ_HIGH = 97;
    // slot positions
    localparam logic [4:0] MCW1_SLOT = 5'h0f;
    localparam logic [4:0] MCW2_SLOT = 5'h1f;
    localparam logic [4:0] PHASE_SLOT = 5'h03;
    localparam logic [4:0] MSW1_SLOT = 5'h0f;
    localparam logic [4:0] MSW2_SLOT = 5'h1f;
    // master control word one fields
    localparam int MCW1_DEBOUNCE_OFF_BIT = 7;
    localparam int MCW1_TRANSPARENT_BIT = 6;
    localparam int MCW1_B8ZS_BIT = 5;
    localparam int MCW1_EIGHT_KHZ_HOLD_BIT = 4;
    localparam int MCW1_EXT_CTRL_BIT = 3;
    localparam int MCW1_ESF_YELLOW_BIT = 2;
    localparam int MCW1_ROBBED_OFF_BIT = 1;
    localparam int MCW1_BIT2_YELLOW_BIT = 0;
    // master control word two field
    localparam int MCW2_FRAMING_FORMAT_BIT = 4;
    // data byte positions: line bit 1 is the msb, bit 8 the lsb
    localparam int LINE_BIT2_POS = 6;
    localparam int LINE_BIT7_POS = 1;
    localparam int LINE_BIT8_POS = 0;
    // reset and idle values
    localparam logic [7:0] MCW1_RESET = 8'h00;
    localparam logic MCW2_FORMAT_RESET = 1'b0;
    localparam logic [7:0] IDLE_WORD = 8'hff;
endpackage

/* File: hw/ttsp_top.sv */
// t1 tdm system port: serial bus side, control word decode, transmit byte processing
// assumes all inputs synchronous to CLK_I; bus clock well below CLK_I/2
`timescale 1ns/1ps
`default_nettype none
module ttsp_top #(
    parameter int DEBOUNCE_FRAMES = ttsp_pkg::DEBOUNCE_FRAMES,
    parameter int EIGHT_KHZ_PERIOD = ttsp_pkg::EIGHT_KHZ_PERIOD,
    parameter int EIGHT_KHZ_HIGH = ttsp_pkg::EIGHT_KHZ_HIGH
) (
    // system
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // tdm bus side
    input wire logic BUS_CLOCK_2M048_I,
    input wire logic BUS_FRAME_PULSE_N_I,
    input wire logic TX_PAYLOAD_STREAM_IN_I,
    input wire logic CONTROL_STREAM_ZERO_IN_I,
    input wire logic SIGNALLING_STREAM_IN_I,
    output logic RX_PAYLOAD_STREAM_OUT_O,
    output logic STATUS_STREAM_OUT_O,
    // status words from the line side
    input wire logic [7:0] PHASE_STATUS_WORD_I,
    input wire logic [7:0] MASTER_STATUS_WORD_ONE_I,
    input wire logic [7:0] MASTER_STATUS_WORD_TWO_I,
    // transmit bytes toward the line
    output logic [7:0] TX_DS1_DATA_O,
    output logic [4:0] TX_DS1_CHANNEL_O,
    output logic TX_DS1_VALID_O,
    input wire logic TX_DS1_READY_I,
    output logic TX_OVERRUN_O,
    output logic TX_B8ZS_EN_O,
    // received bytes from the line
    input wire logic [7:0] RX_DS1_DATA_I,
    input wire logic [4:0] RX_DS1_CHANNEL_I,
    input wire logic [3:0] RX_DS1_SIG_I,
    input wire logic RX_DS1_VALID_I,
    output logic RX_DS1_READY_O,
    // line clocks and data link
    input wire logic EXTRACTED_LINE_CLOCK_I,
    input wire logic TRANSMIT_LINE_CLOCK_I,
    input wire logic RX_LINE_SYNC_I,
    input wire logic TX_DATA_LINK_IN_I,
    input wire logic TX_FDL_REQ_I,
    output logic TX_FDL_BIT_O,
    // mode outputs
    output logic EIGHT_KHZ_OUT_O,
    output logic EXTERNAL_CONTROL_OUT_O,
    output logic FRAMING_FORMAT_SEL_O
);
    typedef struct packed {
        logic bclk_prev;
        logic [7:0] pos;
        logic [7:0] din_sh;
        logic [7:0] ctl_sh;
        logic [7:0] sig_sh;
        logic [7:0] mcw1;
        logic esf;
        logic [4:0] frame_cnt;
        logic [23:0][3:0] tx_sig;
        logic [23:0][7:0] rx_mem;
        logic [23:0][3:0] rx_raw;
        logic [23:0][3:0] rx_stab;
        logic [23:0][5:0] rx_cnt;
        logic rx_payload_stream_out;
        logic status_stream_out;
        logic [1:0][7:0] buf_data;
        logic [1:0][4:0] buf_ch;
        logic [1:0] buf_cnt;
        logic overrun;
        logic rx_ready;
        logic lclk_prev;
        logic [7:0] e8k_cnt;
        logic e8k;
        logic [3:0] fdl_cnt;
        logic fdl;
        logic tx_valid;
        logic b8zs;
    } ttsp_state_type;

    ttsp_state_type s_reg;
    ttsp_state_type s_next;

    // payload slots: every fourth slot starting at 0 is idle
    function automatic logic ttsp_is_data_slot(input logic [4:0] ch);
        return ch[1:0] != 2'b00;
    endfunction

    function automatic logic [4:0] ttsp_data_index(input logic [4:0] ch);
        return ch - {2'b00, ch[4:2]} - 5'h01;
    endfunction

    // control and status slots: every fourth slot starting at 3 is not a line channel
    function automatic logic ttsp_is_ctrl_slot(input logic [4:0] ch);
        return ch[1:0] != 2'b11;
    endfunction

    function automatic logic [4:0] ttsp_ctrl_index(input logic [4:0] ch);
        return ch - {2'b00, ch[4:2]};
    endfunction

    // robbed bit for the frame: {insert, bit}; A in frame 6 through D in frame 24
    function automatic logic [1:0] ttsp_robbed(input logic [4:0] fc, input logic [3:0] sig);
        logic [1:0] r;
        r = 2'b00;
        if (fc == 5'(ttsp_pkg::ROBBED_PERIOD - 1)) begin
            r = {1'b1, sig[3]};
        end else if (fc == 5'(2 * ttsp_pkg::ROBBED_PERIOD - 1)) begin
            r = {1'b1, sig[2]};
        end else if (fc == 5'(3 * ttsp_pkg::ROBBED_PERIOD - 1)) begin
            r = {1'b1, sig[1]};
        end else if (fc == 5'(4 * ttsp_pkg::ROBBED_PERIOD - 1)) begin
            r = {1'b1, sig[0]};
        end
        return r;
    endfunction

    always_comb begin
        logic fall;
        logic rise;
        logic lclk;
        logic [4:0] ch;
        logic [4:0] idx;
        logic [4:0] ridx;
        logic [7:0] din_b;
        logic [7:0] ctl_b;
        logic [7:0] sig_b;
        logic [7:0] tx_b;
        logic [7:0] out_b;
        logic [7:0] st_b;
        logic [1:0] rob;
        fall = 1'b0;
        rise = 1'b0;
        lclk = 1'b0;
        ch = 5'h00;
        idx = 5'h00;
        ridx = 5'h00;
        din_b = 8'h00;
        ctl_b = 8'h00;
        sig_b = 8'h00;
        tx_b = 8'h00;
        out_b = 8'h00;
        st_b = 8'h00;
        rob = 2'b00;
        s_next = s_reg;
        s_next.rx_ready = 1'b1;
        fall = s_reg.bclk_prev & ~BUS_CLOCK_2M048_I;
        rise = ~s_reg.bclk_prev & BUS_CLOCK_2M048_I;
        s_next.bclk_prev = BUS_CLOCK_2M048_I;
        ch = s_reg.pos[7:3];

        // head of the two-entry transmit buffer leaves when the line side takes it
        if (s_reg.buf_cnt != 2'b00 && TX_DS1_READY_I) begin
            s_next.buf_data[0] = s_reg.buf_data[1];
            s_next.buf_ch[0] = s_reg.buf_ch[1];
            s_next.buf_cnt = s_reg.buf_cnt - 2'b01;
        end

        if (fall) begin
            din_b = {s_reg.din_sh[6:0], TX_PAYLOAD_STREAM_IN_I}; // R02
            ctl_b = {s_reg.ctl_sh[6:0], CONTROL_STREAM_ZERO_IN_I};
            sig_b = {s_reg.sig_sh[6:0], SIGNALLING_STREAM_IN_I};
            s_next.din_sh = din_b;
            s_next.ctl_sh = ctl_b;
            s_next.sig_sh = sig_b;
            if (s_reg.pos[2:0] == 3'h7) begin
                if (ttsp_is_data_slot(ch)) begin // R03
                    idx = ttsp_data_index(ch);
                    tx_b = din_b;
                    rob = ttsp_robbed(s_reg.frame_cnt, s_reg.tx_sig[idx]);
                    if (!s_reg.mcw1[ttsp_pkg::MCW1_ROBBED_OFF_BIT] && rob[1]) begin
                        tx_b[ttsp_pkg::LINE_BIT8_POS] = rob[0]; // R16
                    end
                    if (s_reg.mcw1[ttsp_pkg::MCW1_BIT2_YELLOW_BIT]) begin
                        tx_b[ttsp_pkg::LINE_BIT2_POS] = 1'b0; // R17
                    end
                    if (!s_reg.mcw1[ttsp_pkg::MCW1_TRANSPARENT_BIT] && !s_reg.mcw1[ttsp_pkg::MCW1_B8ZS_BIT]
                        && tx_b == 8'h00) begin
                        tx_b[ttsp_pkg::LINE_BIT7_POS] = 1'b1; // R12
                    end
                    // a full buffer drops the word and flags it
                    if (s_next.buf_cnt == 2'b10) begin
                        s_next.overrun = 1'b1;
                    end else begin
                        s_next.buf_data[s_next.buf_cnt[0]] = tx_b;
                        s_next.buf_ch[s_next.buf_cnt[0]] = idx + 5'h01;
                        s_next.buf_cnt = s_next.buf_cnt + 2'b01;
                    end
                end
                if (ttsp_is_ctrl_slot(ch)) begin
                    s_next.tx_sig[ttsp_ctrl_index(ch)] = sig_b[3:0]; // R08
                end
                if (ch == ttsp_pkg::MCW1_SLOT) begin
                    s_next.mcw1 = ctl_b; // R07 R19
                end
                if (ch == ttsp_pkg::MCW2_SLOT) begin
                    s_next.esf = ctl_b[ttsp_pkg::MCW2_FRAMING_FORMAT_BIT]; // R18 R19
                end
            end
            if (!BUS_FRAME_PULSE_N_I) begin
                s_next.pos = 8'h00; // R01
                if (s_reg.frame_cnt == 5'(ttsp_pkg::FRAMES_PER_SUPERFRAME - 1)) begin
                    s_next.frame_cnt = 5'h00;
                end else begin
                    s_next.frame_cnt = s_reg.frame_cnt + 5'h01;
                end
            end else begin
                s_next.pos = s_reg.pos + 8'h01; // R01
            end
        end

        if (rise) begin
            if (ttsp_is_data_slot(ch)) begin
                out_b = s_reg.rx_mem[ttsp_data_index(ch)];
            end else begin
                out_b = ttsp_pkg::IDLE_WORD; // R05
            end
            if (ch == ttsp_pkg::PHASE_SLOT) begin
                st_b = PHASE_STATUS_WORD_I; // R06
            end else if (ch == ttsp_pkg::MSW1_SLOT) begin
                st_b = MASTER_STATUS_WORD_ONE_I;
            end else if (ch == ttsp_pkg::MSW2_SLOT) begin
                st_b = MASTER_STATUS_WORD_TWO_I;
            end else if (!ttsp_is_ctrl_slot(ch)) begin
                st_b = ttsp_pkg::IDLE_WORD;
            end else if (s_reg.mcw1[ttsp_pkg::MCW1_DEBOUNCE_OFF_BIT]) begin
                st_b = {4'h0, s_reg.rx_raw[ttsp_ctrl_index(ch)]}; // R09
            end else begin
                st_b = {4'h0, s_reg.rx_stab[ttsp_ctrl_index(ch)]}; // R09
            end
            s_next.rx_payload_stream_out = out_b[~s_reg.pos[2:0]]; // R04
            s_next.status_stream_out = st_b[~s_reg.pos[2:0]]; // R06
        end

        // received bytes and signalling; one arrival per channel per line frame
        if (RX_DS1_VALID_I && RX_DS1_CHANNEL_I != 5'h00 && RX_DS1_CHANNEL_I <= 5'(ttsp_pkg::LINE_CHANNELS)) begin
            ridx = RX_DS1_CHANNEL_I - 5'h01;
            s_next.rx_mem[ridx] = RX_DS1_DATA_I;
            if (RX_DS1_SIG_I == s_reg.rx_raw[ridx]) begin
                if (s_reg.rx_cnt[ridx] == 6'(DEBOUNCE_FRAMES - 1)) begin
                    s_next.rx_stab[ridx] = RX_DS1_SIG_I; // R09
                end
                if (s_reg.rx_cnt[ridx] != 6'(DEBOUNCE_FRAMES)) begin
                    s_next.rx_cnt[ridx] = s_reg.rx_cnt[ridx] + 6'h01;
                end
            end else begin
                s_next.rx_raw[ridx] = RX_DS1_SIG_I;
                s_next.rx_cnt[ridx] = 6'h00;
            end
        end

        // 8 kHz from the extracted clock while in sync, else from the transmit clock
        lclk = RX_LINE_SYNC_I ? EXTRACTED_LINE_CLOCK_I : TRANSMIT_LINE_CLOCK_I;
        s_next.lclk_prev = lclk;
        if (lclk && !s_reg.lclk_prev) begin
            if (s_reg.e8k_cnt == 8'(EIGHT_KHZ_PERIOD - 1)) begin
                s_next.e8k_cnt = 8'h00;
            end else begin
                s_next.e8k_cnt = s_reg.e8k_cnt + 8'h01;
            end
        end
        s_next.e8k = s_reg.mcw1[ttsp_pkg::MCW1_EIGHT_KHZ_HOLD_BIT] ||
            (s_reg.e8k_cnt < 8'(EIGHT_KHZ_HIGH)); // R13

        // data link: yellow pattern in ESF with control bit 2 set, otherwise the serial link input
        if (TX_FDL_REQ_I) begin
            s_next.fdl_cnt = s_reg.fdl_cnt + 4'h1;
        end
        if (s_reg.esf && s_reg.mcw1[ttsp_pkg::MCW1_ESF_YELLOW_BIT]) begin
            s_next.fdl = ~s_next.fdl_cnt[3]; // R15
        end else begin
            s_next.fdl = TX_DATA_LINK_IN_I; // R15
        end

        // buffer valid and coder enable are registered copies of next state, so no output is decoded
        s_next.tx_valid = s_next.buf_cnt != 2'b00;
        s_next.b8zs = s_next.mcw1[ttsp_pkg::MCW1_B8ZS_BIT] & ~s_next.mcw1[ttsp_pkg::MCW1_TRANSPARENT_BIT]; // R10 R11
    end

    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            s_reg <= '0;
            s_reg.mcw1 <= ttsp_pkg::MCW1_RESET;
            s_reg.esf <= ttsp_pkg::MCW2_FORMAT_RESET;
            s_reg.rx_payload_stream_out <= 1'b1;
            s_reg.status_stream_out <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign RX_PAYLOAD_STREAM_OUT_O = s_reg.rx_payload_stream_out;
    assign STATUS_STREAM_OUT_O = s_reg.status_stream_out;
    assign TX_DS1_DATA_O = s_reg.buf_data[0];
    assign TX_DS1_CHANNEL_O = s_reg.buf_ch[0];
    assign TX_DS1_VALID_O = s_reg.tx_valid;
    assign TX_OVERRUN_O = s_reg.overrun;
    assign TX_B8ZS_EN_O = s_reg.b8zs; // R10 R11
    assign RX_DS1_READY_O = s_reg.rx_ready;
    assign TX_FDL_BIT_O = s_reg.fdl;
    assign EIGHT_KHZ_OUT_O = s_reg.e8k;
    assign EXTERNAL_CONTROL_OUT_O = s_reg.mcw1[ttsp_pkg::MCW1_EXT_CTRL_BIT]; // R14
    assign FRAMING_FORMAT_SEL_O = s_reg.esf;
endmodule
`default_nettype wire

/* File: verification/ttsp_checker.sv */
// assertions on the top ports of the tdm system port
// assumes the bind below attaches it to ttsp_top
`timescale 1ns/1ps
`default_nettype none
module ttsp_checker (
    // watched ports
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic BUS_CLOCK_2M048_I,
    input wire logic TX_DS1_READY_I,
    input wire logic RX_PAYLOAD_STREAM_OUT_O,
    input wire logic STATUS_STREAM_OUT_O,
    input wire logic [7:0] TX_DS1_DATA_O,
    input wire logic [4:0] TX_DS1_CHANNEL_O,
    input wire logic TX_DS1_VALID_O,
    input wire logic TX_OVERRUN_O,
    input wire logic TX_B8ZS_EN_O,
    input wire logic RX_DS1_READY_O,
    input wire logic EXTERNAL_CONTROL_OUT_O,
    input wire logic FRAMING_FORMAT_SEL_O
);
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    AST_RX_ON_RISE: assert property ($changed(RX_PAYLOAD_STREAM_OUT_O) |->
        $past(BUS_CLOCK_2M048_I) && !$past(BUS_CLOCK_2M048_I, 2)) else $error("payload out moved off a rise");
    AST_ST_ON_RISE: assert property ($changed(STATUS_STREAM_OUT_O) |->
        $past(BUS_CLOCK_2M048_I) && !$past(BUS_CLOCK_2M048_I, 2)) else $error("status out moved off a rise");
    AST_EXTERNAL_CONTROL_OUT_AT_BYTE: assert property ($changed(EXTERNAL_CONTROL_OUT_O) |->
        !$past(BUS_CLOCK_2M048_I) && $past(BUS_CLOCK_2M048_I, 2)) else $error("ext control moved mid byte");
    AST_B8ZS_AT_BYTE: assert property ($changed(TX_B8ZS_EN_O) |->
        !$past(BUS_CLOCK_2M048_I) && $past(BUS_CLOCK_2M048_I, 2)) else $error("b8zs enable moved mid byte");
    AST_FMT_AT_BYTE: assert property ($changed(FRAMING_FORMAT_SEL_O) |->
        !$past(BUS_CLOCK_2M048_I) && $past(BUS_CLOCK_2M048_I, 2)) else $error("format moved mid byte");
    AST_TX_HOLD: assert property (TX_DS1_VALID_O && !TX_DS1_READY_I |=> TX_DS1_VALID_O &&
        $stable(TX_DS1_DATA_O) && $stable(TX_DS1_CHANNEL_O)) else $error("stalled tx byte changed");
    AST_TX_CHANNEL: assert property (TX_DS1_VALID_O |->
        TX_DS1_CHANNEL_O inside {[5'h01:5'h18]}) else $error("tx channel out of range");
    AST_OVR_STICKY: assert property (TX_OVERRUN_O |=> TX_OVERRUN_O) else $error("overrun cleared");
    AST_RX_READY: assert property ($past(RESET_N_I) |-> RX_DS1_READY_O) else $error("rx ready low");
endmodule
bind ttsp_top ttsp_checker u_chk (.CLK_I(CLK_I), .RESET_N_I(RESET_N_I),
    .BUS_CLOCK_2M048_I(BUS_CLOCK_2M048_I), .TX_DS1_READY_I(TX_DS1_READY_I),
    .RX_PAYLOAD_STREAM_OUT_O(RX_PAYLOAD_STREAM_OUT_O), .STATUS_STREAM_OUT_O(STATUS_STREAM_OUT_O),
    .TX_DS1_DATA_O(TX_DS1_DATA_O), .TX_DS1_CHANNEL_O(TX_DS1_CHANNEL_O), .TX_DS1_VALID_O(TX_DS1_VALID_O),
    .TX_OVERRUN_O(TX_OVERRUN_O), .TX_B8ZS_EN_O(TX_B8ZS_EN_O), .RX_DS1_READY_O(RX_DS1_READY_O),
    .EXTERNAL_CONTROL_OUT_O(EXTERNAL_CONTROL_OUT_O), .FRAMING_FORMAT_SEL_O(FRAMING_FORMAT_SEL_O));
`default_nettype wire

/* File: verification/ttsp_ctrl_model.sv */
// tdm controller model: bus clock, frame pulse, input streams, output capture
// assumes clk_i is the 10 MHz system clock; bus clock is clk_i / 8
`timescale 1ns/1ps
`default_nettype none
module ttsp_ctrl_model (
    // system
    input wire logic clk_i,
    // words to send
    input wire logic [7:0] mcw1_i,
    input wire logic [7:0] mcw2_i,
    input wire logic [7:0] pay_i,
    input wire logic [3:0] sig_i,
    // bus
    output logic bclk_o,
    output logic fp_n_o,
    output logic pay_o,
    output logic ctl_o,
    output logic sig_o,
    input wire logic rx_i,
    input wire logic st_i,
    // captured bytes
    output logic [7:0] rx0_o,
    output logic [7:0] rx1_o,
    output logic [7:0] st0_o,
    output logic [7:0] st3_o,
    output logic [7:0] st15_o,
    output logic [7:0] st31_o
);
    logic [2:0] cnt;
    logic [7:0] pos;
    logic [7:0] rsr;
    logic [7:0] ssr;
    logic [7:0] cw;
    logic [7:0] sg;
    assign bclk_o = cnt[2];
    assign cw = (pos[7:3] == 5'h0f) ? mcw1_i : (pos[7:3] == 5'h1f) ? mcw2_i : 8'h00;
    assign sg = {4'h0, sig_i};
    initial begin
        cnt = 3'h0;
        pos = 8'h00;
        {fp_n_o, pay_o, ctl_o, sig_o} = 4'hf;
    end
    always @(posedge clk_i) begin
        cnt <= cnt + 3'h1;
        // data changes just after the bus clock rise, msb first
        if (cnt == 3'h3) begin
            fp_n_o <= pos != 8'hff;
            pay_o <= pay_i[~pos[2:0]];
            ctl_o <= cw[~pos[2:0]];
            sig_o <= sg[~pos[2:0]];
        end
        if (cnt == 3'h7) begin
            rsr <= {rsr[6:0], rx_i};
            ssr <= {ssr[6:0], st_i};
            if (pos == 8'h07) begin
                rx0_o <= {rsr[6:0], rx_i};
                st0_o <= {ssr[6:0], st_i};
            end
            if (pos == 8'h0f) rx1_o <= {rsr[6:0], rx_i};
            if (pos == 8'h1f) st3_o <= {ssr[6:0], st_i};
            if (pos == 8'h7f) st15_o <= {ssr[6:0], st_i};
            if (pos == 8'hff) st31_o <= {ssr[6:0], st_i};
            pos <= pos + 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: verification/ttsp_top_bench.sv */
// self-checking bench for ttsp_top with the controller model on the bus
// assumes shortened debounce and 8 kHz counts
`timescale 1ns/1ps
`default_nettype none
module ttsp_top_bench;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] mcw1 = 8'h02, mcw2 = 8'h00, pay = 8'h00, rx_data = 8'h00;
    logic [3:0] sig = 4'h0;
    logic [4:0] rx_ch = 5'h00;
    logic tx_ready = 1'b1, rx_valid = 1'b0, lclk = 1'b0, link = 1'b0, fdl_req = 1'b0, sync = 1'b0, xclk = 1'b0;
    logic [7:0] phase_status_word = 8'h5a, msw_a = 8'h11, msw_b = 8'h22;
    logic bclk, fp_n, pay_s, ctl_s, sig_s, rx_s, st_s, tx_valid, overrun, b8zs, rx_ready, fdl_bit, khz, external_control_out, esf;
    logic [7:0] rx0, rx1, st0, st3, st15, st31, tx_data;
    logic [4:0] tx_ch;
    int errors = 0;
    int check_count = 0;
    int cycles = 0;
    ttsp_top #(.DEBOUNCE_FRAMES(2), .EIGHT_KHZ_PERIOD(5), .EIGHT_KHZ_HIGH(3)) uut (
        .CLK_I(clk), .RESET_N_I(rst_n), .BUS_CLOCK_2M048_I(bclk), .BUS_FRAME_PULSE_N_I(fp_n),
        .TX_PAYLOAD_STREAM_IN_I(pay_s), .CONTROL_STREAM_ZERO_IN_I(ctl_s), .SIGNALLING_STREAM_IN_I(sig_s),
        .RX_PAYLOAD_STREAM_OUT_O(rx_s), .STATUS_STREAM_OUT_O(st_s), .PHASE_STATUS_WORD_I(phase_status_word),
        .MASTER_STATUS_WORD_ONE_I(msw_a), .MASTER_STATUS_WORD_TWO_I(msw_b), .TX_DS1_DATA_O(tx_data),
        .TX_DS1_CHANNEL_O(tx_ch), .TX_DS1_VALID_O(tx_valid), .TX_DS1_READY_I(tx_ready), .TX_OVERRUN_O(overrun),
        .TX_B8ZS_EN_O(b8zs), .RX_DS1_DATA_I(rx_data), .RX_DS1_CHANNEL_I(rx_ch), .RX_DS1_SIG_I(sig),
        .RX_DS1_VALID_I(rx_valid), .RX_DS1_READY_O(rx_ready), .EXTRACTED_LINE_CLOCK_I(xclk),
        .TRANSMIT_LINE_CLOCK_I(lclk), .RX_LINE_SYNC_I(sync), .TX_DATA_LINK_IN_I(link), .TX_FDL_REQ_I(fdl_req),
        .TX_FDL_BIT_O(fdl_bit), .EIGHT_KHZ_OUT_O(khz), .EXTERNAL_CONTROL_OUT_O(external_control_out), .FRAMING_FORMAT_SEL_O(esf));
    ttsp_ctrl_model ctrl (.clk_i(clk), .mcw1_i(mcw1), .mcw2_i(mcw2), .pay_i(pay), .sig_i(sig), .bclk_o(bclk),
        .fp_n_o(fp_n), .pay_o(pay_s), .ctl_o(ctl_s), .sig_o(sig_s), .rx_i(rx_s), .st_i(st_s),
        .rx0_o(rx0), .rx1_o(rx1), .st0_o(st0), .st3_o(st3), .st15_o(st15), .st31_o(st31));
    initial begin
        forever #50 clk = ~clk;
    end
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // transmit line clock at a quarter of the system clock, extracted clock at an eighth
    always @(posedge clk) begin
        cycles++;
        lclk <= #1 cycles[1];
        xclk <= #1 cycles[2];
        if (cycles == 70000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_byte;
        int n = 0;
        while (tx_valid !== 1'b1 && n < 300) begin
            tick(1);
            n++;
        end
        check("tx valid", tx_valid, 8'h01);
        check("tx channel", {7'h0, tx_ch >= 5'h01 && tx_ch <= 5'h18}, 8'h01);
    endtask
    task automatic test_reset;
        check("ready in reset", rx_ready, 8'h00);
        check("stream in reset", rx_s, 8'h01);
        rst_n = 1'b1;
        tick(2);
        check("ready", rx_ready, 8'h01);
        $display("reset test done");
    endtask
    task automatic test_modes;
        logic [7:0] m [4] = '{8'h1a, 8'h22, 8'h42, 8'he3};
        logic [7:0] p [4] = '{8'h00, 8'h00, 8'h00, 8'hff};
        logic [7:0] e;
        int lows;
        for (int i = 0; i < 4; i++) begin
            mcw1 = m[i];
            pay = p[i];
            tick(4200);
            e = p[i];
            if (m[i][0]) e[6] = 1'b0;
            if (m[i][6:5] == 2'b00 && e == 8'h00) e[1] = 1'b1;
            wait_byte();
            check("tx byte", tx_data, e);
            check("ext ctl", external_control_out, {7'h0, m[i][3]});
            check("b8zs", b8zs, {7'h0, m[i][5] & ~m[i][6]});
            lows = 0;
            repeat (64) begin
                tick(1);
                lows += (khz === 1'b0);
            end
            check("8k held", {7'h0, lows == 0}, {7'h0, m[i][4]});
        end
        $display("mode test done");
    endtask
    task automatic test_buffer;
        logic [4:0] c;
        int n = 0;
        tx_ready = 1'b0;
        while (overrun !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        check("overrun", overrun, 8'h01);
        check("held", tx_valid, 8'h01);
        c = tx_ch;
        tx_ready = 1'b1;
        tick(1);
        check("fifo order", {3'h0, tx_ch}, {3'h0, (c == 5'h18) ? 5'h01 : c + 5'h01});
        check("second held", tx_valid, 8'h01);
        tick(1);
        check("drained", tx_valid, 8'h00);
        $display("buffer test done");
    endtask
    task automatic test_status;
        mcw1 = 8'h82;
        sig = 4'h9;
        rx_ch = 5'h01;
        rx_data = 8'h3c;
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        tick(4200);
        check("phase slot", st3, 8'h5a);
        check("idle slot", rx0, 8'hff);
        check("rx slot 1", rx1, 8'h3c);
        check("chan status", st0, 8'h09);
        check("master status one", st15, msw_a);
        check("master status two", st31, msw_b);
        mcw1 = 8'h02;
        sig = 4'h6;
        rx_valid = 1'b1;
        tick(1);
        rx_valid = 1'b0;
        tick(4200);
        check("debounce holds", st0, 8'h00);
        rx_valid = 1'b1;
        tick(2);
        rx_valid = 1'b0;
        tick(2200);
        check("debounced", st0, 8'h06);
        $display("status test done");
    endtask
    task automatic test_robbed;
        int bytes = 0;
        int robbed = 0;
        int plain = 0;
        int rises = 0;
        logic prev;
        mcw1 = 8'h00;
        pay = 8'hff;
        sig = 4'h0;
        sync = 1'b1;
        tick(4200);
        prev = khz;
        repeat (400) begin
            tick(1);
            rises += (khz === 1'b1 && prev === 1'b0);
            prev = khz;
        end
        check("8k from extracted", rises[7:0], 8'h0a);
        sync = 1'b0;
        repeat (12288) begin
            tick(1);
            bytes += (tx_valid === 1'b1);
            robbed += (tx_valid === 1'b1 && tx_data === 8'hfe);
            plain += (tx_valid === 1'b1 && tx_data === 8'hff);
        end
        check("bytes in six frames", bytes[7:0], 8'h90);
        check("robbed bytes", robbed[7:0], 8'h18);
        check("plain bytes", plain[7:0], 8'h78);
        $display("robbed bit test done");
    endtask
    task automatic test_fdl;
        int ones = 0;
        link = 1'b1;
        tick(2);
        check("link high", fdl_bit, 8'h01);
        link = 1'b0;
        tick(2);
        check("link low", fdl_bit, 8'h00);
        mcw2 = 8'h10;
        mcw1 = 8'h06;
        tick(4200);
        check("esf", esf, 8'h01);
        repeat (16) begin
            fdl_req = 1'b1;
            tick(1);
            fdl_req = 1'b0;
            tick(1);
            ones += (fdl_bit === 1'b1);
        end
        check("yellow ones", ones[7:0], 8'h08);
        $display("data link test done");
    endtask
    initial begin
        tick(2);
        test_reset();
        test_modes();
        test_buffer();
        test_status();
        test_robbed();
        test_fdl();
        report_and_stop();
    end
endmodule
`default_nettype wire
